// ---- design/cfa_defs.vh ----
// Constants for the condition flags and addressing block.
// How it works
// - Sixteen-bit program counter holds next fetch address.
// - Reset vector picked by cause and mode.
// - Eight-bit flag register: five flags, masks, stop.
// - Push, pull, index-add, transfers other than TAP leave flags alone.
// - Carry from carry/borrow, errors, shifts through it.
// - Overflow set on overflow, else cleared.
// - Zero set on zero result, else cleared.
// - Compare subtracts, updates flags, stores nothing.
// - Index increment/decrement touch only zero flag.
// - Negative flag copies result top bit.
// - Interrupt mask holds maskable requests; reset sets.
// - Interrupt entry sets mask after stacking.
// - Half carry from bit three on eight-bit adds.
// - Pin mask set by reset and non-maskable entry.
// - Pin mask cleared only by software restore.
// - Stop disabled acts as no operation.
// - Words stored high byte first, unaligned.
// - Eight-bit opcodes, prebyte selects map page.
// - Instruction is one to four bytes.
// - Immediate operand width matches, address follows opcode.
// - Direct mode high address byte is zero.
// - Indexed adds unsigned byte to index.
// - Taken branch adds signed byte to counter.
`ifndef CFA_DEFS_VH
`define CFA_DEFS_VH
// ==========================================================
// Flag register bit positions.
`define CFA_B_S 7
`define CFA_B_X 6
`define CFA_B_H 5
`define CFA_B_I 4
`define CFA_B_N 3
`define CFA_B_Z 2
`define CFA_B_V 1
`define CFA_B_C 0
`define CFA_CCR_RST 8'hD0
// ==========================================================
// Reset vectors.
`define CFA_VEC_HI_NORM 8'hFF
`define CFA_VEC_HI_BOOT 8'hBF
`define CFA_VEC_LO_POR  8'hFE
`define CFA_VEC_LO_CLKM 8'hFC
`define CFA_VEC_LO_WDOG 8'hFA
`define CFA_CAUSE_CLKM  2'h1
`define CFA_CAUSE_WDOG  2'h2
// ==========================================================
// Prebytes and pages.
`define CFA_PRE_P1 8'h18
`define CFA_PRE_P2 8'h1A
`define CFA_PRE_P3 8'hCD
`define CFA_PG_0   2'h0
`define CFA_PG_1   2'h1
`define CFA_PG_2   2'h2
`define CFA_PG_3   2'h3
`define CFA_OP_BSR 8'h8D
`define CFA_HI_REL 4'h2
// ==========================================================
// Addressing modes.
`define CFA_M_IMM 3'h0
`define CFA_M_DIR 3'h1
`define CFA_M_EXT 3'h2
`define CFA_M_IDX 3'h3
`define CFA_M_INH 3'h4
`define CFA_M_REL 3'h5
// ==========================================================
// Executor commands.
`define CFA_C_NONE 4'h0
`define CFA_C_ALU  4'h1
`define CFA_C_INX  4'h2
`define CFA_C_DEX  4'h3
`define CFA_C_INY  4'h4
`define CFA_C_DEY  4'h5
`define CFA_C_ABX  4'h6
`define CFA_C_ABY  4'h7
`define CFA_C_TAP  4'h8
`define CFA_C_RTI  4'h9
`define CFA_C_BRA  4'hA
`define CFA_C_JMP  4'hB
`define CFA_C_SEI  4'hC
`define CFA_C_CLI  4'hD
`define CFA_C_STOP 4'hE
`define CFA_C_INTR 4'hF
// ==========================================================
// Arithmetic operations.
`define CFA_A_ADD 4'h0
`define CFA_A_ADC 4'h1
`define CFA_A_SUB 4'h2
`define CFA_A_SBC 4'h3
`define CFA_A_CMP 4'h4
`define CFA_A_AND 4'h5
`define CFA_A_OR  4'h6
`define CFA_A_EOR 4'h7
`define CFA_A_LD  4'h8
`define CFA_A_ASL 4'h9
`define CFA_A_LSR 4'hA
`define CFA_A_ROL 4'hB
`define CFA_A_ROR 4'hC
`define CFA_A_ERR 4'hD
`define CFA_A_ASR 4'hE
`endif

// ---- design/cfa_flag_alu.v ----
// Arithmetic unit producing result and condition flags.
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defs.vh"
module cfa_flag_alu (
   // Operation.
   input  wire [3:0]  i_op,
   input  wire        i_wide,
   input  wire [15:0] i_a,
   input  wire [15:0] i_b,
   input  wire        i_cin,
   // Result.
   output reg  [15:0] o_result,
   output reg  [4:0]  o_flags,
   output reg  [4:0]  o_mask,
   output reg         o_store
);
   // ==========================================================
   // Flags are ordered H N Z V C.
   reg  [16:0] ext;
   reg  [15:0] r;
   reg         c;
   reg         v;
   reg         h;
   reg         sa;
   reg         sb;
   reg         sr;
   wire [15:0] msk = i_wide ? 16'hFFFF : 16'h00FF;
   wire [15:0] a   = i_a & msk;
   wire [15:0] b   = i_b & msk;
   wire        am  = i_wide ? a[15] : a[7];
   wire        bm  = i_wide ? b[15] : b[7];
   always @* begin
      ext = 17'h0_0000;
      r = 16'h0000;
      c = i_cin;
      v = 1'b0;
      h = 1'b0;
      o_mask = 5'h0E;
      o_store = 1'b1;
      case (i_op)
         `CFA_A_ADD, `CFA_A_ADC: begin
            ext = {1'b0, a} + {1'b0, b} + {16'h0000, (i_op == `CFA_A_ADC) & i_cin};
            r = ext[15:0];
            c = i_wide ? ext[16] : ext[8];
            h = ext[4] ^ a[4] ^ b[4];
            o_mask = i_wide ? 5'h0F : 5'h1F;
         end
         `CFA_A_SUB, `CFA_A_SBC, `CFA_A_CMP: begin
            ext = {1'b0, a} - {1'b0, b} - {16'h0000, (i_op == `CFA_A_SBC) & i_cin};
            r = ext[15:0];
            c = i_wide ? ext[16] : ext[8];
            o_mask = 5'h0F;
            o_store = (i_op != `CFA_A_CMP);
         end
         `CFA_A_AND: r = a & b;
         `CFA_A_OR:  r = a | b;
         `CFA_A_EOR: r = a ^ b;
         `CFA_A_LD:  r = b;
         `CFA_A_ASL, `CFA_A_ROL: begin
            r = {a[14:0], (i_op == `CFA_A_ROL) & i_cin};
            c = am;
            o_mask = 5'h0F;
         end
         `CFA_A_LSR, `CFA_A_ROR, `CFA_A_ASR: begin
            r = a >> 1;
            if (i_op != `CFA_A_LSR) begin
               if (i_wide)
                  r[15] = (i_op == `CFA_A_ROR) ? i_cin : a[15];
               else
                  r[7] = (i_op == `CFA_A_ROR) ? i_cin : a[7];
            end
            c = a[0];
            o_mask = 5'h0F;
         end
         `CFA_A_ERR: begin
            c = b[0];
            o_mask = 5'h01;
            o_store = 1'b0;
         end
         default: o_mask = 5'h00;
      endcase
      r = r & msk;
      sa = am;
      sb = bm;
      sr = i_wide ? r[15] : r[7];
      if (i_op == `CFA_A_ADD || i_op == `CFA_A_ADC)
         v = (sa == sb) && (sr != sa);
      else if (i_op == `CFA_A_SUB || i_op == `CFA_A_SBC || i_op == `CFA_A_CMP)
         v = (sa != sb) && (sr != sa);
      else if (i_op >= `CFA_A_ASL && i_op != `CFA_A_ERR)
         v = sr ^ c;
      o_result = r;
      o_flags = {h, sr, (r == 16'h0000), v, c};
   end
endmodule
`default_nettype wire

// ---- design/cfa_core.v ----
// Program counter, condition flags and instruction address former.
`timescale 1ns/1ps
`default_nettype none
`include "cfa_defs.vh"
module cfa_core (
   // Clock and reset.
   input  wire        i_clk,
   input  wire        i_rst,
   // Reset cause and operating mode.
   input  wire [1:0]  i_rst_cause,
   input  wire        i_boot_mode,
   // Memory read port.
   output wire [15:0] o_mem_addr,
   output wire        o_mem_rd,
   input  wire        i_mem_valid,
   input  wire [7:0]  i_mem_data,
   // Decoded instruction.
   output wire        o_instr_valid,
   output reg  [1:0]  o_page,
   output reg  [7:0]  o_opcode,
   output reg  [2:0]  o_mode,
   output reg  [15:0] o_ea,
   output reg  [15:0] o_operand,
   output reg  [2:0]  o_instr_len,
   // Executor command.
   input  wire        i_exec_valid,
   input  wire [3:0]  i_exec_cmd,
   input  wire [3:0]  i_exec_aluop,
   input  wire        i_exec_wide,
   input  wire [15:0] i_exec_opa,
   input  wire [15:0] i_exec_opb,
   input  wire [7:0]  i_exec_ccr,
   input  wire [15:0] i_exec_data,
   input  wire        i_exec_taken,
   input  wire        i_exec_nmi,
   // Results.
   output reg  [15:0] o_result,
   output reg         o_result_valid,
   output reg         o_stop_enter,
   // Interrupt requests.
   input  wire        i_irq_req,
   input  wire        i_pin_nonmaskable_interrupt_req,
   output wire        o_irq_pending,
   output wire        o_pin_nonmaskable_interrupt_pending,
   // Register views.
   output wire [15:0] o_pc,
   output wire [7:0]  o_ccr,
   output wire [15:0] o_x,
   output wire [15:0] o_y
);
   // ==========================================================
   // States.
   localparam ST_RESET = 3'h0;
   localparam ST_VHI   = 3'h1;
   localparam ST_VLO   = 3'h2;
   localparam ST_OPC   = 3'h3;
   localparam ST_OPND  = 3'h4;
   localparam ST_EXEC  = 3'h5;

   reg  [2:0]  state_reg;
   reg  [15:0] pc_reg;
   reg  [7:0]  ccr_reg;
   reg  [15:0] x_reg;
   reg  [15:0] y_reg;
   reg  [15:0] vec_reg;
   reg  [1:0]  need_reg;
   reg  [7:0]  lo_vec;
   reg  [2:0]  mode_next;
   reg  [1:0]  need_next;
   reg  [15:0] idx_val;
   reg  [7:0]  ccr_load;
   wire [15:0] alu_res;
   wire [4:0]  alu_flags;
   wire [4:0]  alu_mask;
   wire        alu_store;
   wire        take     = i_mem_valid & o_mem_rd;
   wire [3:0]  hi_nib   = i_mem_data[7:4];
   wire [3:0]  lo_nib   = i_mem_data[3:0];
   wire [15:0] pc_inc   = pc_reg + 16'h0001;
   wire [15:0] full     = {o_operand[7:0], i_mem_data};
   wire        is_pre   = (i_mem_data == `CFA_PRE_P1) || (i_mem_data == `CFA_PRE_P2) ||
                          (i_mem_data == `CFA_PRE_P3);
   wire [15:0] x_inc    = x_reg + 16'h0001;
   wire [15:0] x_dec    = x_reg - 16'h0001;
   wire [15:0] y_inc    = y_reg + 16'h0001;
   wire [15:0] y_dec    = y_reg - 16'h0001;

   assign o_mem_rd       = (state_reg == ST_VHI) || (state_reg == ST_VLO) ||
                           (state_reg == ST_OPC) || (state_reg == ST_OPND);
   assign o_mem_addr     = (state_reg == ST_VHI || state_reg == ST_VLO) ? vec_reg : pc_reg;
   assign o_instr_valid  = (state_reg == ST_EXEC);
   assign o_irq_pending  = i_irq_req & ~ccr_reg[`CFA_B_I];
   assign o_pin_nonmaskable_interrupt_pending = i_pin_nonmaskable_interrupt_req & ~ccr_reg[`CFA_B_X];
   assign o_pc           = pc_reg;
   assign o_ccr          = ccr_reg;
   assign o_x            = x_reg;
   assign o_y            = y_reg;

   // ==========================================================
   // Arithmetic flag unit.
   cfa_flag_alu u_alu (
      .i_op     (i_exec_aluop),
      .i_wide   (i_exec_wide),
      .i_a      (i_exec_opa),
      .i_b      (i_exec_opb),
      .i_cin    (ccr_reg[`CFA_B_C]),
      .o_result (alu_res),
      .o_flags  (alu_flags),
      .o_mask   (alu_mask),
      .o_store  (alu_store)
   );

   // ==========================================================
   // Opcode classification.
   always @* begin
      if (i_mem_data == `CFA_OP_BSR || hi_nib == `CFA_HI_REL)
         mode_next = `CFA_M_REL;
      else if (i_mem_data[7]) begin
         case (i_mem_data[5:4])
            2'h0:    mode_next = `CFA_M_IMM;
            2'h1:    mode_next = `CFA_M_DIR;
            2'h2:    mode_next = `CFA_M_IDX;
            default: mode_next = `CFA_M_EXT;
         endcase
      end else
         mode_next = `CFA_M_INH;
      case (mode_next)
         `CFA_M_IMM: need_next = (lo_nib == 4'h3 || lo_nib == 4'hC || lo_nib == 4'hE) ? 2'h2 : 2'h1;
         `CFA_M_EXT: need_next = 2'h2;
         `CFA_M_INH: need_next = 2'h0;
         default:    need_next = 2'h1;
      endcase
   end

   // ==========================================================
   // Index choice and reset vector choice.
   always @* begin
      idx_val = (o_page == `CFA_PG_1 || o_page == `CFA_PG_3) ? y_reg : x_reg;
      if (i_rst_cause == `CFA_CAUSE_CLKM)
         lo_vec = `CFA_VEC_LO_CLKM;
      else if (i_rst_cause == `CFA_CAUSE_WDOG)
         lo_vec = `CFA_VEC_LO_WDOG;
      else
         lo_vec = `CFA_VEC_LO_POR;
   end

   // ==========================================================
   // Flag load for transfers and returns.
   always @* begin
      ccr_load = {i_exec_ccr[`CFA_B_S], ccr_reg[`CFA_B_X] & i_exec_ccr[`CFA_B_X],
                  i_exec_ccr[5:0]};
   end

   // ==========================================================
   // Sequencer and register updates.
   always @(posedge i_clk) begin
      o_result_valid <= 1'b0;
      o_stop_enter <= 1'b0;
      if (i_rst) begin
         state_reg <= ST_RESET;
         pc_reg <= 16'h0000;
         ccr_reg <= `CFA_CCR_RST;
         x_reg <= 16'h0000;
         y_reg <= 16'h0000;
         vec_reg <= 16'h0000;
         need_reg <= 2'h0;
         o_page <= `CFA_PG_0;
         o_opcode <= 8'h00;
         o_mode <= `CFA_M_INH;
         o_ea <= 16'h0000;
         o_operand <= 16'h0000;
         o_instr_len <= 3'h0;
         o_result <= 16'h0000;
      end else begin
         case (state_reg)
            ST_RESET: begin
               vec_reg <= {i_boot_mode ? `CFA_VEC_HI_BOOT : `CFA_VEC_HI_NORM, lo_vec};
               state_reg <= ST_VHI;
            end
            ST_VHI: if (take) begin
               pc_reg[15:8] <= i_mem_data;
               vec_reg <= vec_reg + 16'h0001;
               state_reg <= ST_VLO;
            end
            ST_VLO: if (take) begin
               pc_reg[7:0] <= i_mem_data;
               o_page <= `CFA_PG_0;
               o_instr_len <= 3'h0;
               state_reg <= ST_OPC;
            end
            ST_OPC: if (take) begin
               pc_reg <= pc_inc;
               o_instr_len <= o_instr_len + 3'h1;
               if (is_pre && o_page == `CFA_PG_0) begin
                  if (i_mem_data == `CFA_PRE_P1)
                     o_page <= `CFA_PG_1;
                  else if (i_mem_data == `CFA_PRE_P2)
                     o_page <= `CFA_PG_2;
                  else
                     o_page <= `CFA_PG_3;
               end else begin
                  o_opcode <= i_mem_data;
                  o_mode <= mode_next;
                  o_ea <= pc_inc;
                  o_operand <= 16'h0000;
                  need_reg <= need_next;
                  state_reg <= (need_next == 2'h0) ? ST_EXEC : ST_OPND;
               end
            end
            ST_OPND: if (take) begin
               pc_reg <= pc_inc;
               o_instr_len <= o_instr_len + 3'h1;
               o_operand <= full;
               need_reg <= need_reg - 2'h1;
               if (need_reg == 2'h1) begin
                  state_reg <= ST_EXEC;
                  case (o_mode)
                     `CFA_M_DIR: o_ea <= {8'h00, i_mem_data};
                     `CFA_M_IDX: o_ea <= idx_val + {8'h00, i_mem_data};
                     `CFA_M_EXT: o_ea <= full;
                     `CFA_M_REL: o_ea <= pc_inc + {{8{i_mem_data[7]}}, i_mem_data};
                     default:    o_ea <= o_ea;
                  endcase
               end
            end
            ST_EXEC: if (i_exec_valid) begin
               state_reg <= ST_OPC;
               o_page <= `CFA_PG_0;
               o_instr_len <= 3'h0;
               case (i_exec_cmd)
                  `CFA_C_ALU: begin
                     if (alu_mask[4])
                        ccr_reg[`CFA_B_H] <= alu_flags[4];
                     if (alu_mask[3])
                        ccr_reg[`CFA_B_N] <= alu_flags[3];
                     if (alu_mask[2])
                        ccr_reg[`CFA_B_Z] <= alu_flags[2];
                     if (alu_mask[1])
                        ccr_reg[`CFA_B_V] <= alu_flags[1];
                     if (alu_mask[0])
                        ccr_reg[`CFA_B_C] <= alu_flags[0];
                     if (alu_store) begin
                        o_result <= alu_res;
                        o_result_valid <= 1'b1;
                     end
                  end
                  `CFA_C_INX: begin
                     x_reg <= x_inc;
                     ccr_reg[`CFA_B_Z] <= (x_inc == 16'h0000);
                  end
                  `CFA_C_DEX: begin
                     x_reg <= x_dec;
                     ccr_reg[`CFA_B_Z] <= (x_dec == 16'h0000);
                  end
                  `CFA_C_INY: begin
                     y_reg <= y_inc;
                     ccr_reg[`CFA_B_Z] <= (y_inc == 16'h0000);
                  end
                  `CFA_C_DEY: begin
                     y_reg <= y_dec;
                     ccr_reg[`CFA_B_Z] <= (y_dec == 16'h0000);
                  end
                  `CFA_C_ABX: begin
                     x_reg <= x_reg + {8'h00, i_exec_opb[7:0]};
                  end
                  `CFA_C_ABY: begin
                     y_reg <= y_reg + {8'h00, i_exec_opb[7:0]};
                  end
                  `CFA_C_TAP: begin
                     ccr_reg <= ccr_load;
                  end
                  `CFA_C_RTI: begin
                     ccr_reg <= ccr_load;
                     pc_reg <= i_exec_data;
                  end
                  `CFA_C_BRA: if (i_exec_taken)
                     pc_reg <= o_ea;
                  `CFA_C_JMP: begin
                     pc_reg <= i_exec_data;
                  end
                  `CFA_C_SEI: begin
                     ccr_reg[`CFA_B_I] <= 1'b1;
                  end
                  `CFA_C_CLI: begin
                     ccr_reg[`CFA_B_I] <= 1'b0;
                  end
                  `CFA_C_STOP: o_stop_enter <= ~ccr_reg[`CFA_B_S];
                  `CFA_C_INTR: begin
                     ccr_reg[`CFA_B_I] <= 1'b1;
                     if (i_exec_nmi)
                        ccr_reg[`CFA_B_X] <= 1'b1;
                     vec_reg <= i_exec_data;
                     state_reg <= ST_VHI;
                  end
                  default: ccr_reg <= ccr_reg;
               endcase
            end
            default: state_reg <= ST_RESET;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- tb/cfa_mem_model.sv ----
// Byte memory that answers the core's read requests.
`timescale 1ns/1ps
`default_nettype none
module cfa_mem_model (
   // Clock and pacing.
   input  wire logic        i_clk,
   input  wire logic        i_slow,
   // Read port.
   input  wire logic [15:0] i_addr,
   input  wire logic        i_rd,
   output var  logic        o_valid,
   output var  logic [7:0]  o_data
);
   // ==========================================================
   // Storage and answer.
   logic [7:0] mem [0:65535];
   logic       odd_reg = 1'b0;
   initial begin
      o_valid = 1'b0;
      o_data  = 8'h00;
   end
   // Answers at the falling edge; in slow mode only every other cycle.
   // Bytes are handed out one address at a time, so word order is the core's own.
   always @(negedge i_clk) begin
      odd_reg <= ~odd_reg;
      o_valid <= i_rd & (~i_slow | odd_reg);
      o_data  <= (i_rd & (~i_slow | odd_reg)) ? mem[i_addr] : ~o_data;
   end
endmodule
`default_nettype wire

// ---- tb/cfa_core_assertions.sv ----
// Concurrent checks on the core's ports.
`timescale 1ns/1ps
`default_nettype none
module cfa_core_assertions (
   // Clock, reset and start mode.
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [1:0]  i_rst_cause,
   input wire logic        i_boot_mode,
   // Memory and executor.
   input wire logic [15:0] o_mem_addr,
   input wire logic        o_mem_rd,
   input wire logic        i_mem_valid,
   input wire logic        i_exec_valid,
   input wire logic [3:0]  i_exec_cmd,
   input wire logic        i_exec_nmi,
   // Decoded instruction and state.
   input wire logic        o_instr_valid,
   input wire logic [1:0]  o_page,
   input wire logic [2:0]  o_mode,
   input wire logic [15:0] o_ea,
   input wire logic [15:0] o_operand,
   input wire logic [2:0]  o_instr_len,
   input wire logic        o_stop_enter,
   input wire logic        o_irq_pending,
   input wire logic [7:0]  o_ccr,
   input wire logic [15:0] o_x,
   input wire logic [15:0] o_y
);
   // ==========================================================
   // Helpers.
   wire        ex  = i_exec_valid & o_instr_valid;
   wire [15:0] vec = {i_boot_mode ? 8'hBF : 8'hFF,
                      (i_rst_cause == 2'h1) ? 8'hFC : (i_rst_cause == 2'h2) ? 8'hFA : 8'hFE};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Assertions.
   a_reset_vector: assert property ($fell(i_rst) |=> o_mem_rd && o_mem_addr == vec)
      else $error("reset vector address wrong");
   a_reset_flags: assert property (disable iff (1'b0) i_rst |=> o_ccr == 8'hD0)
      else $error("flags wrong during reset");
   a_fetch_hold: assert property (o_mem_rd && !i_mem_valid |=> o_mem_rd && $stable(o_mem_addr))
      else $error("fetch address moved before byte taken");
   a_index_zero_only: assert property (ex && i_exec_cmd inside {4'h2, 4'h3, 4'h4, 4'h5} |=>
      (o_ccr & 8'hFB) == ($past(o_ccr) & 8'hFB) && o_ccr[2] == ((($past(i_exec_cmd) < 4'h4) ? o_x : o_y) == 16'h0000))
      else $error("index step flags wrong");
   a_flags_kept: assert property (ex && i_exec_cmd inside {4'h0, 4'h6, 4'h7} |=> $stable(o_ccr))
      else $error("flags changed");
   a_mask_holds: assert property (o_ccr[4] |-> !o_irq_pending)
      else $error("masked request shown pending");
   a_entry_masks: assert property (ex && i_exec_cmd == 4'hF |=>
      o_ccr[4] && o_ccr[6] == ($past(o_ccr[6]) | $past(i_exec_nmi)))
      else $error("entry masks wrong");
   a_pin_mask_kept: assert property (o_ccr[6] && !(ex && i_exec_cmd inside {4'h8, 4'h9}) |=> o_ccr[6])
      else $error("pin mask cleared by hardware");
   a_stop_disable: assert property (ex && i_exec_cmd == 4'hE |=> o_stop_enter == !$past(o_ccr[7]))
      else $error("stop pulse wrong");
   a_direct_page: assert property (o_instr_valid && o_mode == 3'h1 |-> o_ea[15:8] == 8'h00)
      else $error("direct high byte not zero");
   a_index_sum: assert property (o_instr_valid && o_mode == 3'h3 |->
      o_ea == (o_page[0] ? o_y : o_x) + {8'h00, o_operand[7:0]})
      else $error("indexed address wrong");
   a_extended_addr: assert property (o_instr_valid && o_mode == 3'h2 |-> o_ea == o_operand)
      else $error("extended address wrong");
   a_length_range: assert property (o_instr_valid |-> o_instr_len >= 3'h1 && o_instr_len <= 3'h5)
      else $error("length out of range");
   // ==========================================================
   // Covers.
   c_stop: cover property (o_stop_enter);
   c_index_y: cover property (o_instr_valid && o_mode == 3'h3 && o_page == 2'h1);
   c_entry: cover property (ex && i_exec_cmd == 4'hF);
endmodule
bind cfa_core cfa_core_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_rst_cause(i_rst_cause),
   .i_boot_mode(i_boot_mode), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_valid(i_mem_valid),
   .i_exec_valid(i_exec_valid), .i_exec_cmd(i_exec_cmd), .i_exec_nmi(i_exec_nmi),
   .o_instr_valid(o_instr_valid), .o_page(o_page), .o_mode(o_mode), .o_ea(o_ea), .o_operand(o_operand),
   .o_instr_len(o_instr_len), .o_stop_enter(o_stop_enter), .o_irq_pending(o_irq_pending),
   .o_ccr(o_ccr), .o_x(o_x), .o_y(o_y));
`default_nettype wire

// ---- tb/cpu_flags_and_addressing_test.sv ----
// Self-checking bench for the flags and addressing core.
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_and_addressing_test;
   // ==========================================================
   // Signals.
   logic        clk = 1'b0, rst = 1'b1, boot = 1'b0, ev = 1'b0, irq = 1'b1, slow = 1'b0;
   logic [1:0]  cause = 2'h0;
   logic [3:0]  cmd = 4'h0, aop = 4'h0;
   logic [15:0] opa = 16'h0000, opb = 16'h0000, dat = 16'h0000;
   logic        mvalid, iv, rd, rv, stp, ipend, xpend;
   logic [1:0]  page;
   logic [2:0]  mode, len;
   logic [7:0]  mdata, condition_code_register, opc;
   logic [15:0] addr, ea, pc, x, y, res, opnd;
   int          n_mismatch = 0, num_checks = 0, i;
   logic [7:0]  prog [0:20] = '{8'h08, 8'h09, 8'h8B, 8'h7F, 8'h3A, 8'h18, 8'hA6, 8'h10, 8'h96, 8'h40,
                                8'hB6, 8'hAB, 8'hCD, 8'h20, 8'hFE, 8'h01, 8'h01, 8'h01, 8'h20, 8'h05, 8'h01};
   cfa_core uut (.i_clk(clk), .i_rst(rst), .i_rst_cause(cause), .i_boot_mode(boot), .o_mem_addr(addr),
      .o_mem_rd(rd), .i_mem_valid(mvalid), .i_mem_data(mdata), .o_instr_valid(iv), .o_page(page),
      .o_opcode(opc), .o_mode(mode), .o_ea(ea), .o_operand(opnd), .o_instr_len(len), .i_exec_valid(ev),
      .i_exec_cmd(cmd), .i_exec_aluop(aop), .i_exec_wide(1'b0), .i_exec_opa(opa), .i_exec_opb(opb),
      .i_exec_ccr(dat[7:0]), .i_exec_data(dat), .i_exec_taken(dat[0]), .i_exec_nmi(1'b1), .o_result(res),
      .o_result_valid(rv), .o_stop_enter(stp), .i_irq_req(irq), .i_pin_nonmaskable_interrupt_req(irq), .o_irq_pending(ipend),
      .o_pin_nonmaskable_interrupt_pending(xpend), .o_pc(pc), .o_ccr(condition_code_register), .o_x(x), .o_y(y));
   cfa_mem_model u_mem (.i_clk(clk), .i_slow(slow), .i_addr(addr), .i_rd(rd), .o_valid(mvalid), .o_data(mdata));
   initial begin
      forever #50 clk = ~clk;
   end
   // ==========================================================
   // Tasks.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_hi(input bit fetch);
      int k;
      for (k = 0; k < 60 && (fetch ? rd : iv) !== 1'b1; k++) @(negedge clk);
      if ((fetch ? rd : iv) !== 1'b1) begin
         check(16'h0000, 16'h0001);
         final_report();
      end
   endtask
   task automatic step(input logic [2:0] m, input logic [15:0] e, input logic [2:0] l, input logic [3:0] c,
                       input logic [3:0] a, input logic [15:0] pa, input logic [15:0] d, input logic [7:0] cc);
      wait_hi(1'b0);
      check(mode, m);
      check(len, l);
      if (m != 3'h4) check(ea, e);
      cmd = c;
      aop = a;
      opa = pa;
      opb = 16'h0005;
      dat = d;
      ev = 1'b1;
      @(negedge clk);
      ev = 1'b0;
      check(condition_code_register, cc);
   endtask
   // ==========================================================
   // Sequence.
   initial begin
      for (i = 0; i < 12; i++) u_mem.mem[{(i < 6) ? 8'hFF : 8'hBF, 8'hFA + 8'(i % 6)}] = i[0] ? 8'h34 : 8'h12;
      for (i = 0; i < 21; i++) u_mem.mem[16'h1234 + 16'(i)] = prog[i];
      for (i = 0; i < 8; i++) begin
         cause = i[1:0];
         boot = i[2];
         slow = i[0];
         rst = 1'b1;
         repeat (6) @(negedge clk);
         rst = 1'b0;
         check(condition_code_register, 8'hD0);
         check(xpend, 1'b0);
         wait_hi(1'b1);
         check(addr, {boot ? 8'hBF : 8'hFF, (cause == 2'h1) ? 8'hFC : (cause == 2'h2) ? 8'hFA : 8'hFE});
         wait_hi(1'b0);
         check(pc, 16'h1235);
      end
      $display("reset vector test done");
      step(3'h4, 16'h0000, 3'h1, 4'h4, 4'h0, 16'h0000, 16'h0000, 8'hD0);
      check(y, 16'h0001);
      step(3'h4, 16'h0000, 3'h1, 4'h5, 4'h0, 16'h0000, 16'h0000, 8'hD4);
      step(3'h0, 16'h1237, 3'h2, 4'h1, 4'h0, 16'h007B, 16'h0000, 8'hFA);
      check(rv, 1'b1);
      check(res[7:0], 8'h80);
      step(3'h4, 16'h0000, 3'h1, 4'h7, 4'h0, 16'h0000, 16'h0000, 8'hFA);
      check(y, 16'h0005);
      check(x, 16'h0000);
      wait_hi(1'b0);
      check(page, 2'h1);
      step(3'h3, 16'h0015, 3'h3, 4'h1, 4'h4, 16'h0005, 16'h0000, 8'hF4);
      check(opc, 8'hA6);
      check(rv, 1'b0);
      step(3'h1, 16'h0040, 3'h2, 4'h1, 4'h9, 16'h0081, 16'h0000, 8'hF3);
      check(res[7:0], 8'h02);
      check(ipend, 1'b0);
      step(3'h2, 16'hABCD, 3'h3, 4'h8, 4'h0, 16'h0000, 16'h0000, 8'h00);
      check(ipend, 1'b1);
      check(xpend, 1'b1);
      check(opnd, 16'hABCD);
      step(3'h5, 16'h1241, 3'h2, 4'hA, 4'h0, 16'h0000, 16'h0001, 8'h00);
      check(pc, 16'h1241);
      step(3'h5, 16'h1241, 3'h2, 4'h0, 4'h0, 16'h0000, 16'h0000, 8'h00);
      check(pc, 16'h1243);
      step(3'h4, 16'h0000, 3'h1, 4'hE, 4'h0, 16'h0000, 16'h0000, 8'h00);
      check(stp, 1'b1);
      step(3'h4, 16'h0000, 3'h1, 4'h8, 4'h0, 16'h0000, 16'h00C0, 8'h80);
      step(3'h4, 16'h0000, 3'h1, 4'hE, 4'h0, 16'h0000, 16'h0000, 8'h80);
      check(stp, 1'b0);
      step(3'h5, 16'h124D, 3'h2, 4'hA, 4'h0, 16'h0000, 16'h0000, 8'h80);
      check(pc, 16'h1248);
      step(3'h4, 16'h0000, 3'h1, 4'hF, 4'h0, 16'h0000, 16'h2000, 8'hD0);
      wait_hi(1'b1);
      check(addr, 16'h2000);
      check(xpend, 1'b0);
      $display("program test done");
      final_report();
   end
endmodule
`default_nettype wire
